//--- hdl/crs_pkg.sv
// constants, opcodes and types for the core register set and stack unit
package crs_pkg;
   localparam int          DATA_W        = 8;
   localparam int          ADDR_W        = 16;
   // stack page high bytes selected by the page bit
   localparam logic [7:0]  STACK_PAGE0   = 8'h00;
   localparam logic [7:0]  STACK_PAGE1   = 8'h01;
   // mode register address and field position
   localparam logic [15:0] MODE_REG_ADDR = 16'h003B;
   localparam int          MODE_PAGE_BIT = 2;
   // status image bit positions
   localparam int          PS_BRK_BIT    = 4;
   // reset values
   localparam logic [7:0]  SP_RST        = 8'hFF;
   localparam logic [7:0]  BYTE_RST      = 8'h00;
   localparam logic [15:0] PC_RST        = 16'h0000;
   localparam logic [7:0]  PS_RST        = 8'h04;

   // operation codes presented on the command port
   typedef enum logic [4:0] {
      CRS_OP_NOP       = 5'h00,
      CRS_OP_LOAD_A    = 5'h01,
      CRS_OP_LOAD_X    = 5'h02,
      CRS_OP_LOAD_Y    = 5'h03,
      CRS_OP_LOAD_SP   = 5'h04,
      CRS_OP_LOAD_PS   = 5'h05,
      CRS_OP_PC_INC    = 5'h06,
      CRS_OP_PC_LOAD   = 5'h07,
      CRS_OP_PUSH_A    = 5'h08,
      CRS_OP_PUSH_PS   = 5'h09,
      CRS_OP_PUSH_BRK  = 5'h0A,
      CRS_OP_POP_A     = 5'h0B,
      CRS_OP_POP_PS    = 5'h0C,
      CRS_OP_PUSH_PCH  = 5'h0D,
      CRS_OP_PUSH_PCL  = 5'h0E,
      CRS_OP_POP_PCL   = 5'h0F,
      CRS_OP_POP_PCH   = 5'h10,
      CRS_OP_HALT      = 5'h11,
      CRS_OP_WAIT      = 5'h12,
      CRS_OP_PRODUCT   = 5'h13,
      CRS_OP_DIVIDE    = 5'h14,
      CRS_OP_FAST_SET  = 5'h15,
      CRS_OP_SLOW_SET  = 5'h16,
      CRS_OP_MODE_WR   = 5'h17
   } crs_op_e;

   // pop sequence: gray coded along idle, read, write back
   typedef enum logic [1:0] {
      CRS_ST_IDLE = 2'b00,
      CRS_ST_READ = 2'b01,
      CRS_ST_DONE = 2'b11
   } crs_state_e;
endpackage : crs_pkg

//--- hdl/crs_stack_mem.sv
// stack memory: 512 bytes over two pages, registered read data
`timescale 1ns/10ps
module crs_stack_mem (
   input  wire logic        sys_clk,   // core clock
   input  wire logic        wr_en,     // write strobe
   input  wire logic [8:0]  wr_addr,   // write address
   input  wire logic [7:0]  wr_data,   // write data
   input  wire logic [8:0]  rd_addr,   // read address
   output logic      [7:0]  rd_data    // registered read data
);
   logic [7:0] mem [0:511];
   logic [7:0] rd_data_nxt;

   // combinational read selection
   always_comb begin
      rd_data_nxt = mem[rd_addr];
   end

   // storage and registered read; no reset so it maps to ram
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= rd_data_nxt;
   end
endmodule : crs_stack_mem

//--- hdl/crs_core_regs.sv
// programmer register set, stack pointer and program counter of the core
//
// Operation
// - fast and slow mode set opcodes are refused as unsupported.
// - halt, wait, multiply and divide opcodes are accepted and performed.
// - accumulator is an 8-bit register carrying data transfers.
// - X indexed address is operand plus the 8-bit X register.
// - Y indexed address is operand plus the 8-bit Y register.
// - stack pointer supplies the low stack address byte.
// - stack high byte is 00h for page bit 0, 01h for 1.
// - stack pointer marks where registers are saved on calls and interrupts.
// - program counter is 16 bits from two byte halves, next instruction.
// - push and pop exist for accumulator and status register.
// - page bit lives in the core mode register at 003Bh.
// - break push stores break flag one; live break flag reads zero.
`timescale 1ns/10ps
module crs_core_regs (
   input  wire logic        sys_clk,        // core clock, 10 MHz
   input  wire logic        sys_rst,        // synchronous reset, active high
   input  wire logic [4:0]  op_code,        // operation, crs_op_e encoding
   input  wire logic        op_valid,       // operation offered
   output logic             op_ready,       // operation can be taken
   input  wire logic [7:0]  op_data,        // byte operand for loads
   input  wire logic [15:0] op_addr,        // address operand
   output logic             op_unsupported, // refused opcode pulse
   output logic             op_done,        // completion pulse
   output logic [7:0]       acc_out,        // accumulator
   output logic [7:0]       idx_x_out,      // index x
   output logic [7:0]       idx_y_out,      // index y
   output logic [7:0]       sp_out,         // stack pointer
   output logic [7:0]       ps_out,         // live status, break flag zero
   output logic [7:0]       mode_out,       // core mode register
   output logic [7:0]       program_counter_high, // pc high half
   output logic [7:0]       program_counter_low,  // pc low half
   output logic [15:0]      stack_addr,     // current stack address
   output logic [15:0]      eff_addr_x,     // operand plus x
   output logic [15:0]      eff_addr_y,     // operand plus y
   output logic [15:0]      product_out,    // a times y result
   output logic             halted,         // oscillator halt state
   output logic             waiting         // wait state
);

   ////////////////////////////////////////////////////////////////////
   // helpers

   // operand plus index, used for both index registers
   function automatic logic [15:0] index_add(input logic [15:0] base,
                                             input logic [7:0]  idx);
      index_add = base + {crs_pkg::BYTE_RST, idx};
   endfunction : index_add

   // stack address from page bit and pointer
   function automatic logic [15:0] stack_of(input logic pg, input logic [7:0] sp);
      stack_of = {(pg ? crs_pkg::STACK_PAGE1 : crs_pkg::STACK_PAGE0), sp};
   endfunction : stack_of

   ////////////////////////////////////////////////////////////////////
   // state

   logic [7:0]  acc_r, acc_nxt;
   logic [7:0]  x_r, x_nxt;
   logic [7:0]  y_r, y_nxt;
   logic [7:0]  sp_r, sp_nxt;
   logic [7:0]  ps_r, ps_nxt;
   logic [7:0]  mode_r, mode_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic [15:0] prod_r, prod_nxt;
   logic        halt_r, halt_nxt;
   logic        wait_r, wait_nxt;
   logic        unsup_r, unsup_nxt;
   logic        done_r, done_nxt;
   logic [4:0]  pop_op_r, pop_op_nxt;
   crs_pkg::crs_state_e st_r, st_nxt;

   logic        mem_we;
   logic [7:0]  mem_wdata;
   logic [8:0]  mem_waddr;
   logic [8:0]  mem_raddr;
   logic [7:0]  mem_rdata;
   logic        take;
   logic        page_bit;

   assign page_bit = mode_r[crs_pkg::MODE_PAGE_BIT];
   assign take     = op_valid && op_ready;
   // pops take three cycles, so new work waits until idle
   assign op_ready = (st_r == crs_pkg::CRS_ST_IDLE);

   ////////////////////////////////////////////////////////////////////
   // stack memory

   crs_stack_mem u_mem (
      .sys_clk (sys_clk),
      .wr_en   (mem_we),
      .wr_addr (mem_waddr),
      .wr_data (mem_wdata),
      .rd_addr (mem_raddr),
      .rd_data (mem_rdata)
   );

   // page bit becomes the ninth memory address bit
   assign mem_waddr = {page_bit, sp_r};
   assign mem_raddr = {page_bit, sp_r};

   ////////////////////////////////////////////////////////////////////
   // next state of the register set

   always_comb begin
      acc_nxt    = acc_r;
      x_nxt      = x_r;
      y_nxt      = y_r;
      sp_nxt     = sp_r;
      ps_nxt     = ps_r;
      mode_nxt   = mode_r;
      pc_nxt     = pc_r;
      prod_nxt   = prod_r;
      halt_nxt   = halt_r;
      wait_nxt   = wait_r;
      unsup_nxt  = 1'b0;
      done_nxt   = 1'b0;
      pop_op_nxt = pop_op_r;
      st_nxt     = st_r;
      mem_we     = 1'b0;
      mem_wdata  = acc_r;
      case (st_r)
         crs_pkg::CRS_ST_IDLE: begin
            if (take) begin
               done_nxt = 1'b1;
               // any accepted opcode leaves halt and wait, as a wakeup would
               halt_nxt = 1'b0;
               wait_nxt = 1'b0;
               case (op_code)
                  crs_pkg::CRS_OP_LOAD_A:   acc_nxt = op_data;
                  crs_pkg::CRS_OP_LOAD_X:   x_nxt   = op_data;
                  crs_pkg::CRS_OP_LOAD_Y:   y_nxt   = op_data;
                  crs_pkg::CRS_OP_LOAD_SP:  sp_nxt  = op_data;
                  crs_pkg::CRS_OP_LOAD_PS: begin
                     ps_nxt = op_data;
                     ps_nxt[crs_pkg::PS_BRK_BIT] = 1'b0;
                  end
                  crs_pkg::CRS_OP_MODE_WR: begin
                     if (op_addr == crs_pkg::MODE_REG_ADDR) begin
                        mode_nxt = op_data;
                     end
                  end
                  crs_pkg::CRS_OP_PC_INC:   pc_nxt  = pc_r + 16'h0001;
                  crs_pkg::CRS_OP_PC_LOAD:  pc_nxt  = op_addr;
                  // pushes: write at stack address, then decrement
                  crs_pkg::CRS_OP_PUSH_A: begin
                     mem_we    = 1'b1;
                     mem_wdata = acc_r;
                     sp_nxt    = sp_r - 8'h01;
                  end
                  crs_pkg::CRS_OP_PUSH_PS, crs_pkg::CRS_OP_PUSH_BRK: begin
                     mem_we    = 1'b1;
                     mem_wdata = ps_r;
                     // only the stored image carries the break mark
                     mem_wdata[crs_pkg::PS_BRK_BIT] =
                        (op_code == crs_pkg::CRS_OP_PUSH_BRK);
                     sp_nxt    = sp_r - 8'h01;
                  end
                  crs_pkg::CRS_OP_PUSH_PCH: begin
                     mem_we    = 1'b1;
                     mem_wdata = pc_r[15:8];
                     sp_nxt    = sp_r - 8'h01;
                  end
                  crs_pkg::CRS_OP_PUSH_PCL: begin
                     mem_we    = 1'b1;
                     mem_wdata = pc_r[7:0];
                     sp_nxt    = sp_r - 8'h01;
                  end
                  // pops: increment first, read on the following cycles
                  crs_pkg::CRS_OP_POP_A, crs_pkg::CRS_OP_POP_PS,
                  crs_pkg::CRS_OP_POP_PCL, crs_pkg::CRS_OP_POP_PCH: begin
                     sp_nxt     = sp_r + 8'h01;
                     pop_op_nxt = op_code;
                     done_nxt   = 1'b0;
                     st_nxt     = crs_pkg::CRS_ST_READ;
                  end
                  crs_pkg::CRS_OP_HALT:     halt_nxt = 1'b1;
                  crs_pkg::CRS_OP_WAIT:     wait_nxt = 1'b1;
                  crs_pkg::CRS_OP_PRODUCT:  prod_nxt = acc_r * y_r;
                  crs_pkg::CRS_OP_DIVIDE: begin
                     // dividend y:a over x; zero divisor leaves a and y alone
                     if (x_r != crs_pkg::BYTE_RST) begin
                        acc_nxt = 8'(({y_r, acc_r}) / {crs_pkg::BYTE_RST, x_r});
                        y_nxt   = 8'(({y_r, acc_r}) % {crs_pkg::BYTE_RST, x_r});
                     end
                  end
                  crs_pkg::CRS_OP_FAST_SET, crs_pkg::CRS_OP_SLOW_SET: begin
                     unsup_nxt = 1'b1;
                     done_nxt  = 1'b0;
                  end
                  crs_pkg::CRS_OP_NOP: ;
                  default: begin
                     unsup_nxt = 1'b1;
                     done_nxt  = 1'b0;
                  end
               endcase
            end
         end
         crs_pkg::CRS_ST_READ: begin
            // memory now reads the byte at the incremented pointer; its registered data shows in done
            st_nxt = crs_pkg::CRS_ST_DONE;
         end
         crs_pkg::CRS_ST_DONE: begin
            done_nxt = 1'b1;
            st_nxt   = crs_pkg::CRS_ST_IDLE;
            case (pop_op_r)
               crs_pkg::CRS_OP_POP_A:   acc_nxt = mem_rdata;
               crs_pkg::CRS_OP_POP_PS: begin
                  ps_nxt = mem_rdata;
                  ps_nxt[crs_pkg::PS_BRK_BIT] = 1'b0;
               end
               crs_pkg::CRS_OP_POP_PCL: pc_nxt  = {pc_r[15:8], mem_rdata};
               crs_pkg::CRS_OP_POP_PCH: pc_nxt  = {mem_rdata, pc_r[7:0]};
               default: ;
            endcase
         end
         default: st_nxt = crs_pkg::CRS_ST_IDLE;
      endcase
   end

   // register the whole set
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         acc_r    <= crs_pkg::BYTE_RST;
         x_r      <= crs_pkg::BYTE_RST;
         y_r      <= crs_pkg::BYTE_RST;
         sp_r     <= crs_pkg::SP_RST;
         ps_r     <= crs_pkg::PS_RST;
         mode_r   <= crs_pkg::BYTE_RST;
         pc_r     <= crs_pkg::PC_RST;
         prod_r   <= crs_pkg::PC_RST;
         halt_r   <= 1'b0;
         wait_r   <= 1'b0;
         unsup_r  <= 1'b0;
         done_r   <= 1'b0;
         pop_op_r <= crs_pkg::CRS_OP_NOP;
         st_r     <= crs_pkg::CRS_ST_IDLE;
      end else begin
         acc_r    <= acc_nxt;
         x_r      <= x_nxt;
         y_r      <= y_nxt;
         sp_r     <= sp_nxt;
         ps_r     <= ps_nxt;
         mode_r   <= mode_nxt;
         pc_r     <= pc_nxt;
         prod_r   <= prod_nxt;
         halt_r   <= halt_nxt;
         wait_r   <= wait_nxt;
         unsup_r  <= unsup_nxt;
         done_r   <= done_nxt;
         pop_op_r <= pop_op_nxt;
         st_r     <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // effective address sums stay combinational from registered index values
   assign eff_addr_x           = index_add(op_addr, x_r);
   assign eff_addr_y           = index_add(op_addr, y_r);
   assign stack_addr           = stack_of(page_bit, sp_r);
   assign acc_out              = acc_r;
   assign idx_x_out            = x_r;
   assign idx_y_out            = y_r;
   assign sp_out               = sp_r;
   assign ps_out               = ps_r;
   assign mode_out             = mode_r;
   assign program_counter_high = pc_r[15:8];
   assign program_counter_low  = pc_r[7:0];
   assign product_out          = prod_r;
   assign halted               = halt_r;
   assign waiting              = wait_r;
   assign op_unsupported       = unsup_r;
   assign op_done              = done_r;

endmodule : crs_core_regs

//--- dv/crs_core_regs_chk.sv
// concurrent checks on the ports of the core register set
`timescale 1ns/10ps
module crs_core_regs_chk (
   input wire logic        sys_clk,              // core clock
   input wire logic        sys_rst,              // sync reset
   input wire logic [4:0]  op_code,              // operation
   input wire logic        op_valid,             // offered
   input wire logic        op_ready,             // can take
   input wire logic [7:0]  op_data,              // load byte
   input wire logic [15:0] op_addr,              // address operand
   input wire logic        op_unsupported,       // refused pulse
   input wire logic        op_done,              // done pulse
   input wire logic [7:0]  idx_x_out,            // index x
   input wire logic [7:0]  sp_out,               // stack pointer
   input wire logic [7:0]  ps_out,               // live status
   input wire logic [7:0]  mode_out,             // mode register
   input wire logic [7:0]  program_counter_high, // pc high
   input wire logic [7:0]  program_counter_low,  // pc low
   input wire logic [15:0] stack_addr,           // stack address
   input wire logic [15:0] eff_addr_x,           // operand plus x
   input wire logic        halted                // halt level
);
   logic take;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // request accepted on this edge
   assign take = op_valid && op_ready;

   sequence s_push;
      take && (op_code inside {5'h08, 5'h09, 5'h0A});
   endsequence
   sequence s_pop;
      take && (op_code inside {5'h0B, 5'h0C});
   endsequence
   // pop holds ready low two cycles, then lands
   sequence s_pop_wait;
      !op_ready [*2];
   endsequence

   a_stack_page_map: assert property (stack_addr == {(mode_out[crs_pkg::MODE_PAGE_BIT] ?
      crs_pkg::STACK_PAGE1 : crs_pkg::STACK_PAGE0), sp_out})
      else $error("stack address does not follow page bit and sp");
   a_index_x_sum: assert property (eff_addr_x == op_addr + {8'h00, idx_x_out})
      else $error("x indexed address wrong");
   a_live_brk_zero: assert property (ps_out[4] == 1'b0)
      else $error("live break flag set");
   a_push_sp_dec: assert property (s_push |=> op_done && sp_out == $past(sp_out) - 8'h01)
      else $error("push did not decrement sp");
   a_pop_sp_inc: assert property (s_pop |=> s_pop_wait ##1
      (op_done && op_ready && sp_out == $past(sp_out, 3) + 8'h01))
      else $error("pop sequence wrong");
   a_refused_op: assert property (take && op_code inside {5'h15, 5'h16} |=> op_unsupported)
      else $error("mode set opcode not refused");
   a_halt_state: assert property (take && op_code == 5'h11 |=> halted)
      else $error("halt not entered");
   a_pc_step: assert property (take && op_code == 5'h06 |=>
      {program_counter_high, program_counter_low} ==
      $past({program_counter_high, program_counter_low}) + 16'h0001)
      else $error("pc did not step by one");
   a_mode_write: assert property (take && op_code == 5'h17 && op_addr == crs_pkg::MODE_REG_ADDR
      |=> mode_out == $past(op_data))
      else $error("mode register write lost");
endmodule : crs_core_regs_chk

//--- dv/crs_core_regs_tb.sv
// self-checking bench for the core register set and stack unit
`timescale 1ns/10ps
module crs_core_regs_tb;
   logic sys_clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0;
   logic [4:0] op_code = 5'h00;
   logic [7:0] op_data = 8'h00;
   logic [15:0] op_addr = 16'h0000;
   logic op_ready, op_unsupported, op_done, halted, waiting;
   logic [7:0] acc_out, idx_x_out, idx_y_out, sp_out, ps_out, mode_out, pc_hi, pc_lo;
   logic [15:0] stack_addr, eff_addr_x, eff_addr_y, product_out;
   // reference model state
   logic [7:0] ma, mx, my, msp, mps, mmode, mem [512];
   logic [15:0] mpc, mprod;
   logic mhalt, mwait, mref;
   logic [31:0] rs = 32'h3BFB0BA2;
   int miscompares = 0, cmp_count = 0;

   crs_core_regs crs_core_regs_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .op_code(op_code),
      .op_valid(op_valid), .op_ready(op_ready), .op_data(op_data), .op_addr(op_addr),
      .op_unsupported(op_unsupported), .op_done(op_done), .acc_out(acc_out),
      .idx_x_out(idx_x_out), .idx_y_out(idx_y_out), .sp_out(sp_out), .ps_out(ps_out),
      .mode_out(mode_out), .program_counter_high(pc_hi), .program_counter_low(pc_lo),
      .stack_addr(stack_addr), .eff_addr_x(eff_addr_x), .eff_addr_y(eff_addr_y),
      .product_out(product_out), .halted(halted), .waiting(waiting));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction : xs

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   // model stack: write then decrement, increment then read
   function automatic void push(input logic [7:0] v);
      mem[{mmode[2], msp}] = v;
      msp--;
   endfunction : push
   function automatic logic [7:0] pop();
      msp++;
      return mem[{mmode[2], msp}];
   endfunction : pop

   task automatic do_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      {ma, mx, my, mmode, mref, mhalt, mwait} = '0;
      msp = crs_pkg::SP_RST;
      mps = crs_pkg::PS_RST;
      {mpc, mprod} = '0;
      #1;
   endtask : do_reset

   task automatic chk_all(input logic [15:0] a);
      chk(acc_out, ma);
      chk(idx_x_out, mx);
      chk(idx_y_out, my);
      chk(sp_out, msp);
      chk(ps_out, mps);
      chk(mode_out, mmode);
      chk({pc_hi, pc_lo}, mpc);
      chk(stack_addr, {7'h00, mmode[2], msp});
      chk(eff_addr_x, a + {8'h00, mx});
      chk(eff_addr_y, a + {8'h00, my});
      chk(product_out, mprod);
      chk({halted, waiting}, {mhalt, mwait});
   endtask : chk_all

   // offer one op, update the model, wait for its pulse
   task automatic do_op(input logic [4:0] c, input logic [7:0] d, input logic [15:0] a);
      int n;
      logic [15:0] dv;
      @(posedge sys_clk);
      op_code <= c;
      op_data <= d;
      op_addr <= a;
      op_valid <= 1'b1;
      @(posedge sys_clk);
      op_valid <= 1'b0;
      {mref, mhalt, mwait} = '0;
      dv = {my, ma};
      case (c)
         5'h00: ;
         5'h01: ma = d;
         5'h02: mx = d;
         5'h03: my = d;
         5'h04: msp = d;
         5'h05: mps = d & 8'hEF;
         5'h06: mpc++;
         5'h07: mpc = a;
         5'h08: push(ma);
         5'h09: push(mps);
         5'h0A: push(mps | 8'h10);
         5'h0B: ma = pop();
         5'h0C: mps = pop() & 8'hEF;
         // the bench saves the pc by explicit pushes, as software must
         5'h0D: push(mpc[15:8]);
         5'h0E: push(mpc[7:0]);
         5'h0F: mpc[7:0] = pop();
         5'h10: mpc[15:8] = pop();
         5'h11: mhalt = 1'b1;
         5'h12: mwait = 1'b1;
         5'h13: mprod = ma * my;
         5'h14: if (mx != 8'h00) {my, ma} = {8'(dv % mx), 8'(dv / mx)};
         5'h17: if (a == crs_pkg::MODE_REG_ADDR) mmode = d;
         default: mref = 1'b1;
      endcase
      // the one-cycle pulse of a plain op stands right after the taking edge
      #1;
      n = 0;
      while (op_done !== 1'b1 && op_unsupported !== 1'b1 && n < 6) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(n < 6, 1'b1);
      chk(op_unsupported, mref);
      chk_all(a);
   endtask : do_op

   initial begin
      logic [31:0] r;
      do_reset();
      chk_all(16'h0000);
      $display("test reset done");
      // fill both stack pages so later pops never read unwritten bytes
      for (int i = 0; i < 512; i++) begin
         if (i == 256)
            do_op(5'h17, 8'h04, crs_pkg::MODE_REG_ADDR);
         r = xs();
         do_op(5'h01, r[7:0], r[31:16]);
         do_op(i[0] ? 5'h08 : 5'h0A, 8'h00, 16'h0000);
      end
      $display("test stack fill done");
      for (int i = 0; i < 600; i++) begin
         r = xs();
         do_op(r[4:0], r[15:8], r[5] ? crs_pkg::MODE_REG_ADDR : r[31:16]);
      end
      $display("test random ops done");
      do_reset();
      chk_all(op_addr);
      do_op(5'h17, 8'h04, 16'h003A);
      do_op(5'h15, 8'h00, 16'h0000);
      do_op(5'h16, 8'h00, 16'h0000);
      $display("test second reset done");
      close_out();
   end

   // watchdog, well past the roughly 3400 cycles the tests need
   initial begin
      #3_000_000;
      miscompares++;
      close_out();
   end
endmodule : crs_core_regs_tb

bind crs_core_regs crs_core_regs_chk crs_core_regs_chk_inst (.sys_clk(sys_clk),
   .sys_rst(sys_rst), .op_code(op_code), .op_valid(op_valid), .op_ready(op_ready),
   .op_data(op_data), .op_addr(op_addr), .op_unsupported(op_unsupported), .op_done(op_done),
   .idx_x_out(idx_x_out), .sp_out(sp_out), .ps_out(ps_out), .mode_out(mode_out),
   .program_counter_high(program_counter_high), .program_counter_low(program_counter_low),
   .stack_addr(stack_addr), .eff_addr_x(eff_addr_x), .halted(halted));
